/* File: bench/spmux_board.sv */
/*
 board-side model: strap resistors and the far-side parties on the muxed
 pads. assumes the testbench picks fitted straps and what the far side
 drives onto each pad.
*/
`timescale 1ns/100ps
module spmux_board (
   input wire logic [3:0] strap_fit,
   input wire logic [3:0] strap_val,
   input wire logic [14:0] pad_out,
   input wire logic [14:0] pad_oe,
   input wire logic [14:0] ext_en,
   input wire logic [14:0] ext_val,
   output logic host_sel,
   output logic pad_volt,
   output logic cpuless,
   output logic serial_sel,
   output logic [14:0] pad_in
);
   // unfitted strap falls back to the internal pull level
   assign host_sel = strap_fit[3] ? strap_val[3] : spmux_pkg::HOST_SEL_DEF;
   assign pad_volt = strap_fit[2] ? strap_val[2] : spmux_pkg::PAD_VOLT_DEF;
   assign cpuless = strap_fit[1] ? strap_val[1] : spmux_pkg::CPULESS_DEF;
   assign serial_sel = strap_fit[0] ? strap_val[0] :
      spmux_pkg::SERIAL_SEL_DEF;
   // far side drives any pad the device leaves undriven, only when its ext_en bit is set
   // an unowned pad shows the inverse of the device's level, not a copy
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) |
      (~pad_oe & ~ext_en & ~pad_out);
endmodule

/* File: bench/strap_sampling_and_pad_mux_test.sv */
/*
 self-checking bench for the strap sampler and pad mux.
 assumes the board model in spmux_board and a short strap delay.
*/
`timescale 1ns/100ps
module strap_sampling_and_pad_mux_test;
   logic SYS_CLK = 1'h0, RST_N = 1'h0;
   logic [3:0] fit = 4'h0, sval = 4'h0;
   logic [14:0] ext_en = 15'h0, ext_val = 15'h0;
   logic sh, sv, sc, ss;
   logic [59:0] PIN_CODE = 60'h0;
   logic [14:0] PAD_IN, PAD_OUT, PAD_OE;
   logic STRAPS_DONE, PAD_3V3, CPULESS;
   logic [1:0] HOST_MODE;
   logic [7:0] g_out = 8'h0, g_oe = 8'h0, a_out = 8'h0, a_oe = 8'h0;
   logic txd = 1'h0, pm = 1'h0, pod = 1'h0, psy = 1'h0, pck = 1'h0;
   logic imc = 1'h0, imw = 1'h0, imd = 1'h0, fck = 1'h0, fcs = 1'h0;
   logic fmo = 1'h0, rxs = 1'h0, txs = 1'h0, creq = 1'h0;
   logic rts = 1'h0, isd = 1'h0, bpri = 1'h0;
   logic PCM_SYNC_IN, PCM_CLK_IN, I2S_SLAVE_CLOCK, FLASH_MASTER_IN;
   logic COEX_TX_GRANT, COEX_RF_BUSY, UART_RXD;
   logic UART_CTS_N, PCM_IN_D, I2S_SLAVE_WORD_SEL, I2S_DATA_IN;
   logic [7:0] GPIO_IN, AUX_GPIO_IN;
   int bad_count = 0, num_checks = 0;

   initial begin
      forever #25 SYS_CLK = ~SYS_CLK;
   end

   spmux_board board (.strap_fit(fit), .strap_val(sval), .pad_out(PAD_OUT),
      .pad_oe(PAD_OE), .ext_en(ext_en), .ext_val(ext_val), .host_sel(sh),
      .pad_volt(sv), .cpuless(sc), .serial_sel(ss), .pad_in(PAD_IN));

   spmux_top #(.STRAP_DELAY(10)) uut (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
      .STRAP_HOST_SEL(sh), .PAD_VOLTAGE_STRAP(sv), .STRAP_CPULESS(sc),
      .STRAP_SERIAL_SEL(ss), .PIN_CODE(PIN_CODE), .PAD_IN(PAD_IN),
      .PAD_OUT(PAD_OUT), .PAD_OE(PAD_OE), .STRAPS_DONE(STRAPS_DONE),
      .HOST_MODE(HOST_MODE), .PAD_3V3(PAD_3V3), .CPULESS(CPULESS),
      .UART_TXD(txd), .UART_RTS_N(rts), .UART_RXD(UART_RXD),
      .UART_CTS_N(UART_CTS_N), .GPIO_OUT(g_out), .GPIO_OE(g_oe),
      .GPIO_IN(GPIO_IN), .AUX_GPIO_OUT(a_out), .AUX_GPIO_OE(a_oe),
      .AUX_GPIO_IN(AUX_GPIO_IN),
      .PCM_MASTER(pm), .PCM_OUT_D(pod), .PCM_SYNC_OUT(psy),
      .PCM_CLK_OUT(pck), .PCM_IN_D(PCM_IN_D), .PCM_SYNC_IN(PCM_SYNC_IN),
      .PCM_CLK_IN(PCM_CLK_IN), .I2S_MASTER_CLOCK(imc),
      .I2S_MASTER_WORD_SEL(imw), .I2S_MASTER_DATA_OUT(imd),
      .I2S_SLAVE_DATA_OUT(isd), .I2S_SLAVE_CLOCK(I2S_SLAVE_CLOCK),
      .I2S_SLAVE_WORD_SEL(I2S_SLAVE_WORD_SEL), .I2S_DATA_IN(I2S_DATA_IN),
      .FLASH_SERIAL_CLOCK(fck),
      .FLASH_CHIP_SELECT_N(fcs), .FLASH_MASTER_OUT(fmo),
      .FLASH_MASTER_IN(FLASH_MASTER_IN), .BT_RX_SLOT(rxs), .BT_TX_SLOT(txs),
      .BT_PRIORITY(bpri), .LINK_INDICATOR(1'h0),
      .LOW_POWER_CLOCK_OUT(1'h0), .HCLK_OUT(1'h0),
      .CLK_REQ_COMBINED(creq), .COEX_TX_GRANT(COEX_TX_GRANT),
      .COEX_RF_BUSY(COEX_RF_BUSY));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(negedge SYS_CLK);
   endtask

   task automatic pad(input int p, input logic oe, input logic val);
      check({14'h0, PAD_OE[p], PAD_OUT[p] & oe}, {14'h0, oe, val});
   endtask

   task automatic code(input int p, input logic [3:0] c);
      step(1);
      PIN_CODE[4*p +: 4] = c;
   endtask

   // reset, then wait a bounded span for the strap results
   task automatic boot(input logic [3:0] f, input logic [3:0] v);
      int n;
      step(1);
      RST_N = 1'h0;
      fit = f;
      sval = v;
      step(12);
      RST_N = 1'h1;
      step(3);
      check({1'h0, PAD_OE}, 16'h0);
      n = 3;
      while (STRAPS_DONE !== 1'h1 && n < 60) begin
         step(1);
         n++;
      end
      check(16'(n >= 12 && n < 60), 16'h1);
   endtask

   task automatic t_straps();
      logic [3:0] tv [6] = '{4'h9, 4'he, 4'h1, 4'h7, 4'h2, 4'h0};
      logic [1:0] tm [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
      logic tp [6] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1};
      boot(4'h0, 4'h0);
      check({14'h0, HOST_MODE}, 16'(spmux_pkg::SPMUX_HOST_SDIO));
      check({15'h0, PAD_3V3}, 16'h0);
      check({15'h0, CPULESS}, 16'h1);
      for (int i = 0; i < 6; i++) begin
         boot(4'hf, tv[i]);
         check({14'h0, HOST_MODE}, {14'h0, tm[i]});
         check({15'h0, PAD_3V3}, {15'h0, tp[i]});
         check({15'h0, CPULESS}, {15'h0, tv[i][1]});
         sval = ~tv[i];
         step(6);
         check({14'h0, HOST_MODE}, {14'h0, tm[i]});
         check({15'h0, PAD_3V3, CPULESS}, {14'h0, tp[i], tv[i][1]});
      end
      boot(4'h0, 4'h0);
   endtask

   task automatic t_uart();
      g_oe = 8'h11;
      g_out = 8'h10;
      txd = 1'h1;
      rts = 1'h1;
      code(3, 4'h0);
      step(3);
      pad(3, 1'h1, 1'h1);
      pad(1, 1'h1, 1'h1);
      pad(13, 1'h1, 1'h0);
      code(3, 4'h7);
      g_out = 8'h01;
      step(3);
      pad(3, 1'h1, 1'h0);
      pad(13, 1'h1, 1'h1);
      ext_en[2:0] = 3'h5;
      ext_val[2:0] = 3'h0;
      step(6);
      check({14'h0, UART_RXD, UART_CTS_N}, 16'h0);
      check({8'h0, GPIO_IN}, 16'h00c3);
   endtask

   task automatic t_audio();
      pm = 1'h1;
      psy = 1'h1;
      pck = 1'h1;
      code(4, 4'h1);
      code(6, 4'h1);
      code(7, 4'h1);
      step(3);
      pad(6, 1'h1, 1'h1);
      pad(7, 1'h1, 1'h1);
      pm = 1'h0;
      ext_en[11:6] = 6'h3b;
      ext_val[11:6] = 6'h21;
      step(6);
      pad(6, 1'h0, 1'h0);
      pad(7, 1'h0, 1'h0);
      check({13'h0, PCM_IN_D, PCM_SYNC_IN, PCM_CLK_IN}, 16'h6);
      imd = 1'h1;
      imc = 1'h1;
      code(5, 4'h5);
      code(11, 4'h5);
      step(3);
      pad(5, 1'h1, 1'h1);
      pad(11, 1'h1, 1'h1);
      code(11, 4'h7);
      step(6);
      pad(11, 1'h0, 1'h0);
      check({13'h0, I2S_SLAVE_CLOCK, I2S_SLAVE_WORD_SEL, I2S_DATA_IN},
            16'h4);
      isd = 1'h1;
      code(8, 4'h4);
      step(3);
      pad(8, 1'h1, 1'h1);
      isd = 1'h0;
      bpri = 1'h1;
      code(8, 4'h7);
      step(3);
      pad(8, 1'h1, 1'h1);
      code(0, 4'h7);
      a_oe = 8'h02;
      a_out = 8'h02;
      step(3);
      pad(0, 1'h1, 1'h1);
   endtask

   task automatic t_flash();
      fck = 1'h1;
      fcs = 1'h0;
      fmo = 1'h1;
      ext_en[4] = 1'h1;
      ext_val[4] = 1'h1;
      for (int p = 4; p < 8; p++) code(p, 4'hf);
      step(6);
      pad(7, 1'h1, 1'h1);
      pad(6, 1'h1, 1'h0);
      pad(5, 1'h1, 1'h1);
      pad(4, 1'h0, 1'h0);
      check({15'h0, FLASH_MASTER_IN}, 16'h1);
   endtask

   task automatic t_coex();
      ext_en[9] = 1'h1;
      ext_val[9] = 1'h1;
      code(9, 4'h7);
      step(6);
      check({15'h0, COEX_TX_GRANT}, 16'h1);
      txs = 1'h1;
      step(2);
      check({15'h0, COEX_RF_BUSY}, 16'h1);
      txs = 1'h0;
      step(2);
      check({15'h0, COEX_RF_BUSY}, 16'h0);
      rxs = 1'h1;
      step(2);
      check({15'h0, COEX_RF_BUSY}, 16'h1);
      creq = 1'h1;
      code(14, 4'h0);
      step(3);
      pad(14, 1'h1, 1'h1);
      a_oe = 8'h80;
      a_out = 8'h00;
      code(14, 4'h7);
      step(3);
      pad(14, 1'h1, 1'h0);
      step(3);
      check({15'h0, AUX_GPIO_IN[7]}, 16'h0);
   endtask

   task automatic wrap_up();
      if (bad_count == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge SYS_CLK);
      bad_count++;
      wrap_up();
   end

   initial begin
      step(12);
      RST_N = 1'h1;
      t_straps();
      t_uart();
      t_audio();
      t_flash();
      t_coex();
      wrap_up();
   end
endmodule

/* File: design/spmux_pad.sv */
/*
 one multiplexed pad: picks the outgoing level and drive enable for the
 selected function. assumes all inputs are on the system clock.
*/
`timescale 1ns/100ps
module spmux_pad #(
   parameter int IDX = 0
) (
   input wire logic [3:0] code,
   input wire logic [15:0] fn_out,
   input wire logic [15:0] fn_oe,
   output logic pad_out,
   output logic pad_oe
);
   // fn_out/fn_oe are indexed by function code, already filtered per pin
   always_comb begin
      pad_out = fn_out[code];
      pad_oe = fn_oe[code];
   end
endmodule

/* File: design/spmux_top.sv */
/*
 strap sampler and pad-function mux for the bluetooth-side pins.
 assumes pins are synchronised here, function codes come from software on
 the same clock, and peripheral cores sit outside on SYS_CLK.
*/
// Behaviour
// - straps sampled at power-on reset choose the operating modes
// - sampling happens some milliseconds after reset release
// - after sampling, strap pins resume their normal function
// - defaults: host 1, voltage 0, cpu-less 1, serial 1
// - host 1 gives sdio; 0 with serial 1 gives spi; else unsupported
// - voltage 0 is 1.8V, 1 is 3.3V; unsupported mode forces 3.3V
// - each mux pin follows its own software function code
// - function codes of different pins are independent
// - code 0 on generic bluetooth gpio gives plain gpio
// - uart pins: 0 uart, 7 gpio; pcm/i2s: 0 gpio,1 pcm,4/5/7 i2s,15 flash
// - auxiliary gpios appear behind pcm pins and the i2s data pins, and on code 7 of cts, rts and clock request
// - pcm sync driven as master, received as slave
// - pcm clock driven as master, received as slave
// - i2s master drives clock, word select, data; slave receives them
// - flash selection is spi master: clock, mosi, cs_n out, miso in
// - rf-busy output high through local receive and transmit slots
// - clock request pin: 0 combined request, 7 auxiliary gpio 7
`timescale 1ns/100ps
module spmux_top #(
   parameter int STRAP_DELAY = spmux_pkg::STRAP_DELAY_CYC
) (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic STRAP_HOST_SEL,
   input wire logic PAD_VOLTAGE_STRAP,
   input wire logic STRAP_CPULESS,
   input wire logic STRAP_SERIAL_SEL,
   input wire logic [59:0] PIN_CODE,
   input wire logic [14:0] PAD_IN,
   output logic [14:0] PAD_OUT,
   output logic [14:0] PAD_OE,
   output logic STRAPS_DONE,
   output logic [1:0] HOST_MODE,
   output logic PAD_3V3,
   output logic CPULESS,
   input wire logic UART_TXD,
   input wire logic UART_RTS_N,
   output logic UART_RXD,
   output logic UART_CTS_N,
   input wire logic [7:0] GPIO_OUT,
   input wire logic [7:0] GPIO_OE,
   output logic [7:0] GPIO_IN,
   input wire logic [7:0] AUX_GPIO_OUT,
   input wire logic [7:0] AUX_GPIO_OE,
   output logic [7:0] AUX_GPIO_IN,
   input wire logic PCM_MASTER,
   input wire logic PCM_OUT_D,
   input wire logic PCM_SYNC_OUT,
   input wire logic PCM_CLK_OUT,
   output logic PCM_IN_D,
   output logic PCM_SYNC_IN,
   output logic PCM_CLK_IN,
   input wire logic I2S_MASTER_CLOCK,
   input wire logic I2S_MASTER_WORD_SEL,
   input wire logic I2S_MASTER_DATA_OUT,
   input wire logic I2S_SLAVE_DATA_OUT,
   output logic I2S_SLAVE_CLOCK,
   output logic I2S_SLAVE_WORD_SEL,
   output logic I2S_DATA_IN,
   input wire logic FLASH_SERIAL_CLOCK,
   input wire logic FLASH_CHIP_SELECT_N,
   input wire logic FLASH_MASTER_OUT,
   output logic FLASH_MASTER_IN,
   input wire logic BT_RX_SLOT,
   input wire logic BT_TX_SLOT,
   input wire logic BT_PRIORITY,
   input wire logic LINK_INDICATOR,
   input wire logic LOW_POWER_CLOCK_OUT,
   input wire logic HCLK_OUT,
   input wire logic CLK_REQ_COMBINED,
   output logic COEX_TX_GRANT,
   output logic COEX_RF_BUSY
);
   localparam int NP = spmux_pkg::NPIN;
   localparam int P_CTS = spmux_pkg::P_CTS, P_RTS = spmux_pkg::P_RTS,
      P_RXD = spmux_pkg::P_RXD, P_TXD = spmux_pkg::P_TXD,
      P_PIN = spmux_pkg::P_PIN, P_POUT = spmux_pkg::P_POUT,
      P_PSYNC = spmux_pkg::P_PSYNC, P_PCLK = spmux_pkg::P_PCLK,
      P_SDO = spmux_pkg::P_SDO, P_SDI = spmux_pkg::P_SDI,
      P_SWS = spmux_pkg::P_SWS, P_SCLK = spmux_pkg::P_SCLK,
      P_G1 = spmux_pkg::P_G1, P_G0 = spmux_pkg::P_G0,
      P_CREQ = spmux_pkg::P_CREQ;

   logic rst_s1, rst_n_s;
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_s1 <= 1'b0;
         rst_n_s <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n_s <= rst_s1;
      end
   end

   // two-stage sync for straps and pad inputs
   logic [3:0] strap_s1, strap_s2;
   logic [NP-1:0] pin_s1, pin_s2;
   always_ff @(posedge SYS_CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
         strap_s1 <= 4'h0;
         strap_s2 <= 4'h0;
         pin_s1 <= '0;
         pin_s2 <= '0;
      end else begin
         strap_s1 <= {STRAP_HOST_SEL, PAD_VOLTAGE_STRAP, STRAP_CPULESS,
                      STRAP_SERIAL_SEL};
         strap_s2 <= strap_s1;
         pin_s1 <= PAD_IN;
         pin_s2 <= pin_s1;
      end
   end

   // strap sequencer
   spmux_pkg::spmux_state_t state, next_state;
   logic [31:0] cnt, next_cnt;
   logic [3:0] straps, next_straps;
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_straps = straps;
      case (state)
         spmux_pkg::SPMUX_WAIT: begin
            next_cnt = cnt + 32'h1;
            if (cnt >= 32'(STRAP_DELAY - 1)) begin
               next_state = spmux_pkg::SPMUX_SAMPLE;
            end
         end
         spmux_pkg::SPMUX_SAMPLE: begin
            next_straps = strap_s2;
            next_state = spmux_pkg::SPMUX_DONE;
         end
         spmux_pkg::SPMUX_DONE: begin
            next_straps = straps;
         end
         default: next_state = spmux_pkg::SPMUX_WAIT;
      endcase
   end
   always_ff @(posedge SYS_CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
         state <= spmux_pkg::SPMUX_WAIT;
         cnt <= 32'h0;
         straps <= {spmux_pkg::HOST_SEL_DEF, spmux_pkg::PAD_VOLT_DEF,
                    spmux_pkg::CPULESS_DEF, spmux_pkg::SERIAL_SEL_DEF};
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         straps <= next_straps;
      end
   end

   wire logic done = (state == spmux_pkg::SPMUX_DONE);
   spmux_pkg::spmux_host_t next_host;
   logic next_3v3;
   always_comb begin
      if (straps[3]) begin
         next_host = spmux_pkg::SPMUX_HOST_SDIO;
      end else if (straps[0]) begin
         next_host = spmux_pkg::SPMUX_HOST_SPI;
      end else begin
         next_host = spmux_pkg::SPMUX_HOST_NONE;
      end
      next_3v3 = (next_host == spmux_pkg::SPMUX_HOST_NONE) ? 1'b1 : straps[2];
   end

   // per-pin function tables: index = function code
   logic [15:0] fo [NP];
   logic [15:0] fe [NP];
   wire logic sync_m = PCM_MASTER;
   always_comb begin
      for (int i = 0; i < NP; i++) begin
         fo[i] = 16'h0000;
         fe[i] = 16'h0000;
      end
      fo[P_RTS][0] = UART_RTS_N;
      fe[P_RTS][0] = 1'b1;
      fo[P_TXD][0] = UART_TXD;
      fe[P_TXD][0] = 1'b1;
      fo[P_CTS][7] = AUX_GPIO_OUT[1];
      fe[P_CTS][7] = AUX_GPIO_OE[1];
      fo[P_RTS][7] = AUX_GPIO_OUT[0];
      fe[P_RTS][7] = AUX_GPIO_OE[0];
      fo[P_RXD][7] = GPIO_OUT[5];
      fe[P_RXD][7] = GPIO_OE[5];
      fo[P_TXD][7] = GPIO_OUT[4];
      fe[P_TXD][7] = GPIO_OE[4];
      // pcm/i2s and generic gpio pins, code 0 gpio
      fo[P_PIN][0] = AUX_GPIO_OUT[3];
      fe[P_PIN][0] = AUX_GPIO_OE[3];
      fo[P_POUT][0] = AUX_GPIO_OUT[2];
      fe[P_POUT][0] = AUX_GPIO_OE[2];
      fo[P_PSYNC][0] = AUX_GPIO_OUT[1];
      fe[P_PSYNC][0] = AUX_GPIO_OE[1];
      fo[P_PCLK][0] = AUX_GPIO_OUT[0];
      fe[P_PCLK][0] = AUX_GPIO_OE[0];
      fo[P_SDO][0] = AUX_GPIO_OUT[5];
      fe[P_SDO][0] = AUX_GPIO_OE[5];
      fo[P_SDI][0] = AUX_GPIO_OUT[6];
      fe[P_SDI][0] = AUX_GPIO_OE[6];
      fo[P_SWS][0] = GPIO_OUT[7];
      fe[P_SWS][0] = GPIO_OE[7];
      fo[P_SCLK][0] = GPIO_OUT[6];
      fe[P_SCLK][0] = GPIO_OE[6];
      fo[P_G1][0] = GPIO_OUT[1];
      fe[P_G1][0] = GPIO_OE[1];
      fo[P_G0][0] = GPIO_OUT[0];
      fe[P_G0][0] = GPIO_OE[0];
      // pcm
      for (int c = 1; c <= 2; c++) begin
         fo[P_POUT][c] = PCM_OUT_D;
         fe[P_POUT][c] = 1'b1;
         fo[P_PSYNC][c] = PCM_SYNC_OUT;
         fe[P_PSYNC][c] = sync_m;
         fo[P_PCLK][c] = PCM_CLK_OUT;
         fe[P_PCLK][c] = sync_m;
      end
      fo[P_SDO][1] = PCM_OUT_D;
      fe[P_SDO][1] = 1'b1;
      fo[P_SWS][1] = PCM_SYNC_OUT;
      fe[P_SWS][1] = sync_m;
      fo[P_SCLK][1] = PCM_CLK_OUT;
      fe[P_SCLK][1] = sync_m;
      // misc code 3/4
      fo[P_PIN][3] = HCLK_OUT;
      fe[P_PIN][3] = 1'b1;
      fo[P_POUT][3] = LINK_INDICATOR;
      fe[P_POUT][3] = 1'b1;
      fo[P_PSYNC][3] = HCLK_OUT;
      fe[P_PSYNC][3] = 1'b1;
      fo[P_SDI][3] = HCLK_OUT;
      fe[P_SDI][3] = 1'b1;
      fo[P_SWS][3] = LINK_INDICATOR;
      fe[P_SWS][3] = 1'b1;
      fo[P_PSYNC][4] = LOW_POWER_CLOCK_OUT;
      fe[P_PSYNC][4] = 1'b1;
      fo[P_SCLK][4] = LOW_POWER_CLOCK_OUT;
      fe[P_SCLK][4] = 1'b1;
      fo[P_SDO][4] = I2S_SLAVE_DATA_OUT;
      fe[P_SDO][4] = 1'b1;
      fo[P_G0][4] = LOW_POWER_CLOCK_OUT;
      fe[P_G0][4] = 1'b1;
      // i2s master (code 5), slave (code 7), bt priority, clock request (codes 0/7), flash (code 15)
      fo[P_POUT][5] = I2S_MASTER_DATA_OUT;
      fe[P_POUT][5] = 1'b1;
      fo[P_PSYNC][5] = I2S_MASTER_WORD_SEL;
      fe[P_PSYNC][5] = 1'b1;
      fo[P_PCLK][5] = I2S_MASTER_CLOCK;
      fe[P_PCLK][5] = 1'b1;
      fo[P_SDO][5] = I2S_MASTER_DATA_OUT;
      fe[P_SDO][5] = 1'b1;
      fo[P_SWS][5] = I2S_MASTER_WORD_SEL;
      fe[P_SWS][5] = 1'b1;
      fo[P_SCLK][5] = I2S_MASTER_CLOCK;
      fe[P_SCLK][5] = 1'b1;
      fo[P_POUT][7] = I2S_SLAVE_DATA_OUT;
      fe[P_POUT][7] = 1'b1;
      fo[P_SDO][7] = BT_PRIORITY;
      fe[P_SDO][7] = 1'b1;
      fo[P_G1][7] = BT_PRIORITY;
      fe[P_G1][7] = 1'b1;
      fo[P_CREQ][0] = CLK_REQ_COMBINED;
      fe[P_CREQ][0] = 1'b1;
      fo[P_CREQ][7] = AUX_GPIO_OUT[7];
      fe[P_CREQ][7] = AUX_GPIO_OE[7];
      fo[P_POUT][15] = FLASH_MASTER_OUT;
      fe[P_POUT][15] = 1'b1;
      fo[P_PSYNC][15] = FLASH_CHIP_SELECT_N;
      fe[P_PSYNC][15] = 1'b1;
      fo[P_PCLK][15] = FLASH_SERIAL_CLOCK;
      fe[P_PCLK][15] = 1'b1;
   end

   logic [NP-1:0] next_out, next_oe;
   genvar g;
   generate
      for (g = 0; g < NP; g++) begin : pad
         spmux_pad #(.IDX(g)) u_pad (
            .code(PIN_CODE[4*g +: 4]),
            .fn_out(fo[g]),
            .fn_oe(fe[g]),
            .pad_out(next_out[g]),
            .pad_oe(next_oe[g])
         );
      end
   endgenerate

   function automatic logic sel(input logic [59:0] codes, input int p,
                                input logic [3:0] c);
      sel = (codes[4*p +: 4] == c);
   endfunction

   // inbound routing
   logic [39:0] next_in;
   always_comb begin
      next_in = 40'h0;
      next_in[0] = sel(PIN_CODE, P_RXD, 4'h0) ? pin_s2[P_RXD] : 1'b1;
      next_in[1] = sel(PIN_CODE, P_CTS, 4'h0) ? pin_s2[P_CTS] : 1'b1;
      next_in[2] = (sel(PIN_CODE, P_PIN, 4'h1) & pin_s2[P_PIN])
                 | (sel(PIN_CODE, P_SDI, 4'h1) & pin_s2[P_SDI])
                 | (sel(PIN_CODE, P_PIN, 4'h2) & pin_s2[P_PIN]);
      next_in[3] = (~sync_m) & (sel(PIN_CODE, P_PSYNC, 4'h1)
                 ? pin_s2[P_PSYNC] : pin_s2[P_SWS]);
      next_in[4] = (~sync_m) & (sel(PIN_CODE, P_PCLK, 4'h1)
                 ? pin_s2[P_PCLK] : pin_s2[P_SCLK]);
      next_in[5] = sel(PIN_CODE, P_PCLK, 4'h7) ? pin_s2[P_PCLK]
                 : pin_s2[P_SCLK];
      next_in[6] = sel(PIN_CODE, P_PSYNC, 4'h7) ? pin_s2[P_PSYNC]
                 : pin_s2[P_SWS];
      next_in[7] = sel(PIN_CODE, P_PIN, 4'h7) ? pin_s2[P_PIN]
                 : pin_s2[P_SDI];
      next_in[8] = sel(PIN_CODE, P_PIN, 4'hf) & pin_s2[P_PIN];
      next_in[9] = sel(PIN_CODE, P_SDI, 4'h7) & pin_s2[P_SDI];
      next_in[10] = BT_RX_SLOT | BT_TX_SLOT;
      next_in[11] = pin_s2[P_G0];
      next_in[12] = pin_s2[P_G1];
      next_in[13] = pin_s2[P_TXD];
      next_in[14] = pin_s2[P_RXD];
      next_in[15] = pin_s2[P_SCLK];
      next_in[16] = pin_s2[P_SWS];
      next_in[17] = pin_s2[P_PCLK];
      next_in[18] = pin_s2[P_PSYNC];
      next_in[19] = pin_s2[P_POUT];
      next_in[20] = pin_s2[P_PIN];
      next_in[21] = pin_s2[P_SDO];
      next_in[22] = pin_s2[P_SDI];
      next_in[23] = pin_s2[P_CREQ];
      next_in[24] = pin_s2[P_CTS];
      next_in[25] = pin_s2[P_RTS];
   end

   always_ff @(posedge SYS_CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
         PAD_OUT <= '0;
         PAD_OE <= '0;
         STRAPS_DONE <= 1'b0;
         HOST_MODE <= spmux_pkg::SPMUX_HOST_SDIO;
         PAD_3V3 <= 1'b0;
         CPULESS <= spmux_pkg::CPULESS_DEF;
         UART_RXD <= 1'b1;
         UART_CTS_N <= 1'b1;
         GPIO_IN <= 8'h00;
         AUX_GPIO_IN <= 8'h00;
         {PCM_IN_D, PCM_SYNC_IN, PCM_CLK_IN} <= 3'h0;
         {I2S_SLAVE_CLOCK, I2S_SLAVE_WORD_SEL, I2S_DATA_IN} <= 3'h0;
         FLASH_MASTER_IN <= 1'b0;
         COEX_TX_GRANT <= 1'b0;
         COEX_RF_BUSY <= 1'b0;
      end else begin
         // pads stay undriven until straps are taken
         PAD_OUT <= done ? next_out : '0;
         PAD_OE <= done ? next_oe : '0;
         STRAPS_DONE <= done;
         HOST_MODE <= next_host;
         PAD_3V3 <= next_3v3;
         CPULESS <= straps[1];
         UART_RXD <= next_in[0];
         UART_CTS_N <= next_in[1];
         PCM_IN_D <= next_in[2];
         PCM_SYNC_IN <= next_in[3];
         PCM_CLK_IN <= next_in[4];
         I2S_SLAVE_CLOCK <= next_in[5];
         I2S_SLAVE_WORD_SEL <= next_in[6];
         I2S_DATA_IN <= next_in[7];
         FLASH_MASTER_IN <= next_in[8];
         COEX_TX_GRANT <= next_in[9];
         COEX_RF_BUSY <= next_in[10];
         GPIO_IN <= {next_in[16], next_in[15], next_in[14], next_in[13],
                     2'h0, next_in[12], next_in[11]};
         AUX_GPIO_IN <= {next_in[23], next_in[22], next_in[21], 1'b0,
                         next_in[20], next_in[19], next_in[18],
                         next_in[17]};
      end
   end

   rf_busy_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_s)
      (BT_RX_SLOT | BT_TX_SLOT) |=> COEX_RF_BUSY)
      else $error("rf busy not raised in slot");
   straps_hold_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_s)
      STRAPS_DONE |=> $stable(CPULESS) && $stable(HOST_MODE))
      else $error("straps changed after sampling");
   sdio_mode_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_s)
      straps[3] |=> HOST_MODE == spmux_pkg::SPMUX_HOST_SDIO)
      else $error("sdio select not honoured");
   unsup_volt_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_s)
      (straps[3] == 1'b0 && straps[0] == 1'b0) |=> PAD_3V3)
      else $error("unsupported mode not 3.3V");
   pads_idle_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_s)
      !done |=> PAD_OE == '0)
      else $error("pad driven before straps taken");
   flash_cs_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_s)
      (done && sel(PIN_CODE, P_PSYNC, 4'hf)) |=>
      PAD_OE[P_PSYNC] && PAD_OUT[P_PSYNC] == $past(FLASH_CHIP_SELECT_N))
      else $error("flash chip select not driven");
   pcm_slave_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_s)
      (done && !PCM_MASTER && sel(PIN_CODE, P_PCLK, 4'h1)) |=>
      !PAD_OE[P_PCLK])
      else $error("pcm clock driven as slave");
   creq_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n_s)
      (done && sel(PIN_CODE, P_CREQ, 4'h0)) |=>
      PAD_OUT[P_CREQ] == $past(CLK_REQ_COMBINED))
      else $error("clock request not routed");
   c_done: cover property (@(posedge SYS_CLK) $rose(STRAPS_DONE));
   c_spi: cover property (@(posedge SYS_CLK)
      HOST_MODE == spmux_pkg::SPMUX_HOST_SPI);
   c_flash: cover property (@(posedge SYS_CLK) PAD_OE[P_PCLK] && done);
endmodule

/* File: shared/spmux_pkg.sv */
/*
 package for the strap sampler and pad-function mux: straps, function codes,
 pin indices and timing. assumes a 20 MHz system clock.
*/
package spmux_pkg;
   localparam int CLK_HZ = 20000000;
   // sampling delay after power-on reset release, in microseconds
   localparam int STRAP_DELAY_US = 2000;
   localparam int STRAP_DELAY_CYC = STRAP_DELAY_US * (CLK_HZ / 1000000);
   // unstrapped defaults (internal pulls)
   localparam logic HOST_SEL_DEF = 1'h1;
   localparam logic PAD_VOLT_DEF = 1'h0;
   localparam logic CPULESS_DEF = 1'h1;
   localparam logic SERIAL_SEL_DEF = 1'h1;
   // function codes
   localparam logic [3:0] FN_0 = 4'h0;
   localparam logic [3:0] FN_PCM = 4'h1;
   localparam logic [3:0] FN_PCM2 = 4'h2;
   localparam logic [3:0] FN_3 = 4'h3;
   localparam logic [3:0] FN_4 = 4'h4;
   localparam logic [3:0] FN_5 = 4'h5;
   localparam logic [3:0] FN_7 = 4'h7;
   localparam logic [3:0] FN_FLASH = 4'hf;
   // mux pin indices
   localparam int NPIN = 15;
   localparam int P_CTS = 0;
   localparam int P_RTS = 1;
   localparam int P_RXD = 2;
   localparam int P_TXD = 3;
   localparam int P_PIN = 4;
   localparam int P_POUT = 5;
   localparam int P_PSYNC = 6;
   localparam int P_PCLK = 7;
   localparam int P_SDO = 8;
   localparam int P_SDI = 9;
   localparam int P_SWS = 10;
   localparam int P_SCLK = 11;
   localparam int P_G1 = 12;
   localparam int P_G0 = 13;
   localparam int P_CREQ = 14;
   typedef enum logic [1:0] {
      SPMUX_WAIT = 2'h0,
      SPMUX_SAMPLE = 2'h1,
      SPMUX_DONE = 2'h3
   } spmux_state_t;
   typedef enum logic [1:0] {
      SPMUX_HOST_SDIO = 2'h0,
      SPMUX_HOST_SPI = 2'h1,
      SPMUX_HOST_NONE = 2'h2
   } spmux_host_t;
endpackage
